// >>> include/shaper_pkg.sv
/*
  shared constants and carrier types of the transmit pulse shaper control.
  assumes one 32-bit apb slave, byte addresses, one register per aligned word.
*/
package shaper_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT = 8'h04;
  localparam logic [7:0] OFS_LEG0 = 8'h08;
  localparam logic [7:0] OFS_LEG1 = 8'h0C;
  localparam logic [7:0] OFS_LEG2 = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [1:0] AMP_PAGE = 2'h1; // paddr[7:6], amplitudes at 0x40..0x7C
  // control word fields
  localparam int CB_TABLE = 0;
  localparam int CB_LBO = 1;
  localparam int CB_T1 = 3;
  localparam int CB_SRES = 4;
  localparam int CB_TXFLT = 5;
  localparam int CB_RXFLT = 6;
  localparam int CB_TERM = 7;
  localparam int CTRL_W = 8;
  // port function fields
  localparam int PF_TXA = 0;
  localparam int PF_RXA = 4;
  localparam int PF_RXB = 8;
  localparam int PORT_W = 12;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [11:0] RST_PORT = 12'h000;
  localparam logic [7:0] RST_LEG0 = 8'h7B;
  localparam logic [7:0] RST_LEG1 = 8'h03;
  localparam logic [7:0] RST_LEG2 = 8'h40;
  localparam logic [7:0] RST_AMP_LO = 8'h38;
  localparam logic [7:0] RST_AMP_HI = 8'h00;
  // internal shortest-range t1 shape used under attenuation in legacy mode
  localparam logic [7:0] INT_LEG0 = 8'hD7;
  localparam logic [7:0] INT_LEG1 = 8'h22;
  localparam logic [7:0] INT_LEG2 = 8'h01;
  // multifunction port codes
  localparam logic [3:0] FN_TX_FLOAT_HI = 4'h8;
  localparam logic [3:0] FN_TX_FLOAT_LO = 4'hE;
  localparam logic [3:0] FN_RX_FLOAT = 4'hD;
  localparam logic [3:0] FN_RX_TERM = 4'h8;
  localparam int NUM_SAMPLES = 16;

  // one symbol request from the transmit coder
  typedef struct packed {
    logic start;
    logic mark;
    logic neg;
  } sym_t;

  // multifunction port pin levels
  typedef struct packed {
    logic tx_a;
    logic rx_a;
    logic rx_b;
  } mfp_t;

  // legacy shape words handed to the analog driver
  typedef struct packed {
    logic [7:0] w0;
    logic [7:0] w1;
    logic [7:0] w2;
  } legacy_t;

  // line side switch controls
  typedef struct packed {
    logic float_tx;
    logic float_rx;
    logic term_sw;
  } line_ctl_t;
endpackage

// >>> src/tx_pulse_shaper_control.sv
/*
  transmit pulse shaper control for one line channel: apb register file,
  16-sample symbol sequencer, legacy shape mux, build-out and float logic.
  assumes apb master on core_clk, pins already synchronous to core_clk.
*/
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module tx_pulse_shaper_control #(
  parameter int NSAMP = shaper_pkg::NUM_SAMPLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // symbol stream and pins
  input wire shaper_pkg::sym_t sym_in,
  input wire shaper_pkg::mfp_t mfp_pins,
  // analog driver controls
  output logic signed [7:0] sample,
  output logic sample_valid,
  output shaper_pkg::legacy_t legacy_shape,
  output logic table_mode,
  output logic [1:0] atten_sel,
  output logic ser_res_sel,
  output shaper_pkg::line_ctl_t line_ctl
);
  import shaper_pkg::*;

  localparam int IW = $clog2(NSAMP);

  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [PORT_W-1:0] port_ff, nxt_port;
  logic [7:0] leg_ff [3], nxt_leg [3];
  logic [7:0] amp_ff [NSAMP], nxt_amp [NSAMP];
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic run_ff, nxt_run, mark_ff, nxt_mark, neg_ff, nxt_neg;
  logic [IW-1:0] idx_ff, nxt_idx;
  logic signed [7:0] sample_ff, nxt_sample;
  logic valid_ff, nxt_valid;
  legacy_t legacy_ff, nxt_legacy;
  logic table_ff, nxt_table, sres_ff, nxt_sres;
  logic [1:0] atten_ff, nxt_atten;
  line_ctl_t line_ff, nxt_line;
  logic acc, wr, hit_amp, hit_fixed, force_int;
  logic [IW-1:0] widx;
  logic [3:0] fn_txa, fn_rxa, fn_rxb;
  logic tx_pin_act;

  // effective build-out: zero unless t1
  function automatic logic [1:0] eff_lbo(input logic [CTRL_W-1:0] c);
    return c[CB_T1] ? c[CB_LBO +: 2] : 2'h0;
  endfunction

  // true for the six fixed register offsets
  function automatic logic fixed_hit(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_PORT || a == OFS_LEG0 ||
      a == OFS_LEG1 || a == OFS_LEG2 || a == OFS_STAT;
  endfunction

  // apb decode; answer one cycle after the access phase opens
  always_comb begin
    acc = psel && penable && !pready_ff;
    hit_amp = paddr[7:6] == AMP_PAGE && paddr[1:0] == 2'h0;
    hit_fixed = fixed_hit(paddr);
    wr = acc && pwrite && !pslverr_ff;
    widx = paddr[2 +: IW];
  end

  // register file next state, sync reset loads documented defaults
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_port = port_ff;
    nxt_leg = leg_ff;
    nxt_amp = amp_ff;
    if (wr && paddr == OFS_CTRL) begin
      nxt_ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr && paddr == OFS_PORT) begin
      nxt_port = pwdata[PORT_W-1:0];
    end
    if (wr && paddr == OFS_LEG0) begin
      nxt_leg[0] = pwdata[7:0];
    end
    if (wr && paddr == OFS_LEG1) begin
      nxt_leg[1] = pwdata[7:0];
    end
    if (wr && paddr == OFS_LEG2) begin
      nxt_leg[2] = pwdata[7:0];
    end
    if (wr && hit_amp) begin
      nxt_amp[widx] = pwdata[7:0];
    end
    if (!rst_b) begin
      nxt_ctrl = RST_CTRL;
      nxt_port = RST_PORT;
      nxt_leg[0] = RST_LEG0;
      nxt_leg[1] = RST_LEG1;
      nxt_leg[2] = RST_LEG2;
      for (int i = 0; i < NSAMP; i++) begin
        nxt_amp[i] = (i < NSAMP / 2) ? RST_AMP_LO : RST_AMP_HI;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    ctrl_ff <= nxt_ctrl;
    port_ff <= nxt_port;
    leg_ff <= nxt_leg;
    amp_ff <= nxt_amp;
  end

  // bus answer; unmapped or misaligned addresses error and write nothing
  always_comb begin
    nxt_pready = acc;
    nxt_pslverr = acc && !(hit_amp || hit_fixed);
    nxt_prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      case (paddr)
        OFS_CTRL: nxt_prdata[CTRL_W-1:0] = ctrl_ff;
        OFS_PORT: nxt_prdata[PORT_W-1:0] = port_ff;
        OFS_LEG0: nxt_prdata[7:0] = leg_ff[0];
        OFS_LEG1: nxt_prdata[7:0] = leg_ff[1];
        OFS_LEG2: nxt_prdata[7:0] = leg_ff[2];
        OFS_STAT: nxt_prdata[9:0] = {mfp_pins, line_ff, force_int, atten_ff, run_ff};
        default: nxt_prdata[7:0] = hit_amp ? amp_ff[widx] : 8'h00;
      endcase
    end
    if (!rst_b) begin
      nxt_pready = 1'b0;
      nxt_pslverr = 1'b0;
      nxt_prdata = 32'h0000_0000;
    end
  end

  // pslverr_ff doubles as the write block, so it must clear between beats
  always_ff @(posedge core_clk) begin
    pready_ff <= nxt_pready;
    pslverr_ff <= nxt_pslverr;
    prdata_ff <= nxt_prdata;
  end

  // symbol sequencer: a new start restarts at sample 0 at once
  always_comb begin
    nxt_run = run_ff;
    nxt_idx = idx_ff;
    nxt_mark = mark_ff;
    nxt_neg = neg_ff;
    if (sym_in.start) begin
      nxt_run = 1'b1;
      nxt_idx = '0;
      nxt_mark = sym_in.mark;
      nxt_neg = sym_in.neg;
    end else if (run_ff) begin
      nxt_idx = IW'(idx_ff + 1'b1);
      nxt_run = idx_ff != IW'(NSAMP - 1);
    end
    if (!rst_b) begin
      nxt_run = 1'b0;
      nxt_idx = '0;
      nxt_mark = 1'b0;
      nxt_neg = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    run_ff <= nxt_run;
    idx_ff <= nxt_idx;
    mark_ff <= nxt_mark;
    neg_ff <= nxt_neg;
  end

  // pin functions
  always_comb begin
    fn_txa = port_ff[PF_TXA +: 4];
    fn_rxa = port_ff[PF_RXA +: 4];
    fn_rxb = port_ff[PF_RXB +: 4];
    tx_pin_act = (fn_txa == FN_TX_FLOAT_HI && mfp_pins.tx_a) ||
      (fn_txa == FN_TX_FLOAT_LO && !mfp_pins.tx_a);
    force_int = !ctrl_ff[CB_TABLE] && eff_lbo(ctrl_ff) != 2'h0;
  end

  // driver outputs; no short detection exists on the main outputs
  always_comb begin
    nxt_table = ctrl_ff[CB_TABLE];
    nxt_atten = eff_lbo(ctrl_ff);
    nxt_sres = ctrl_ff[CB_SRES];
    nxt_valid = run_ff;
    nxt_sample = 8'sh00;
    if (run_ff && mark_ff && ctrl_ff[CB_TABLE]) begin
      // signed amplitude, mirrored for the negative mark
      nxt_sample = neg_ff ? -$signed(amp_ff[idx_ff]) : $signed(amp_ff[idx_ff]);
    end
    nxt_legacy = {leg_ff[0], leg_ff[1], leg_ff[2]};
    if (force_int) begin
      nxt_legacy = {INT_LEG0, INT_LEG1, INT_LEG2};
    end
    nxt_line.float_tx = ctrl_ff[CB_TXFLT] || tx_pin_act;
    nxt_line.float_rx = ctrl_ff[CB_RXFLT];
    if (fn_rxa == FN_RX_FLOAT) begin
      nxt_line.float_rx = ctrl_ff[CB_RXFLT] ^ mfp_pins.rx_a;
    end else if (fn_rxb == FN_RX_FLOAT) begin
      nxt_line.float_rx = ctrl_ff[CB_RXFLT] ^ mfp_pins.rx_b;
    end
    nxt_line.term_sw = ctrl_ff[CB_TERM];
    if (fn_rxa == FN_RX_TERM) begin
      nxt_line.term_sw = !(ctrl_ff[CB_TERM] ^ mfp_pins.rx_a);
    end else if (fn_rxb == FN_RX_TERM) begin
      nxt_line.term_sw = !(ctrl_ff[CB_TERM] ^ mfp_pins.rx_b);
    end
    if (!rst_b) begin
      nxt_table = 1'b0;
      nxt_atten = 2'h0;
      nxt_sres = 1'b0;
      nxt_valid = 1'b0;
      nxt_sample = 8'sh00;
      nxt_legacy = {RST_LEG0, RST_LEG1, RST_LEG2};
      nxt_line = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    table_ff <= nxt_table;
    atten_ff <= nxt_atten;
    sres_ff <= nxt_sres;
    valid_ff <= nxt_valid;
    sample_ff <= nxt_sample;
    legacy_ff <= nxt_legacy;
    line_ff <= nxt_line;
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sample = sample_ff;
  assign sample_valid = valid_ff;
  assign legacy_shape = legacy_ff;
  assign table_mode = table_ff;
  assign atten_sel = atten_ff;
  assign ser_res_sel = sres_ff;
  assign line_ctl = line_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence sym_begin;
    sym_in.start;
  endsequence
  sequence first_sample;
    ##1 (run_ff && idx_ff == '0) ##1 valid_ff;
  endsequence

  a_seq_start: assert property (sym_begin |-> first_sample)
    else $error("symbol start did not produce sample 0");
  a_seq_step: assert property (run_ff && !sym_in.start && idx_ff != IW'(NSAMP - 1) |=>
    run_ff && idx_ff == IW'($past(idx_ff) + 1'b1))
    else $error("sample index did not advance by one");
  a_table_sample: assert property (run_ff && mark_ff && !neg_ff && ctrl_ff[CB_TABLE] |=>
    sample_ff == $signed($past(amp_ff[idx_ff])))
    else $error("table sample differs from amplitude register");
  a_legacy_zero: assert property (run_ff && !ctrl_ff[CB_TABLE] |=> sample_ff == 8'sh00)
    else $error("legacy mode emitted table samples");
  a_reset_defaults: assert property ($rose(rst_b) |-> !ctrl_ff[CB_TABLE] && leg_ff[0] == RST_LEG0 &&
    leg_ff[2] == RST_LEG2 && amp_ff[0] == RST_AMP_LO && amp_ff[NSAMP-1] == RST_AMP_HI)
    else $error("reset values wrong");
  a_lbo_non_t1: assert property (!ctrl_ff[CB_T1] |=> atten_ff == 2'h0)
    else $error("attenuation outside t1 mode");
  a_lbo_forced: assert property (force_int |=> legacy_ff == {INT_LEG0, INT_LEG1, INT_LEG2})
    else $error("legacy words not forced under build-out");
  a_lbo_table: assert property (ctrl_ff[CB_TABLE] && ctrl_ff[CB_T1] |=>
    atten_ff == $past(ctrl_ff[CB_LBO +: 2]) && legacy_ff == {$past(leg_ff[0]), $past(leg_ff[1]), $past(leg_ff[2])})
    else $error("table mode build-out path wrong");
  a_tx_float: assert property (fn_txa == FN_TX_FLOAT_LO && !mfp_pins.tx_a |=> line_ff.float_tx)
    else $error("low-active float input ignored");
  a_rx_float: assert property (fn_rxa == FN_RX_FLOAT |=>
    line_ff.float_rx == ($past(mfp_pins.rx_a) ^ $past(ctrl_ff[CB_RXFLT])))
    else $error("receive float not pin xor bit");
  a_term_equiv: assert property (fn_rxa == FN_RX_TERM |=>
    line_ff.term_sw == ($past(mfp_pins.rx_a) == $past(ctrl_ff[CB_TERM])))
    else $error("termination switch not equivalence");
endmodule

// >>> verif/line_driver_model.sv
/*
  stand-in for the analog line driver: captures the samples of one symbol.
  assumes samples arrive on core_clk while sample_valid is high.
*/
`timescale 1ns/100ps
module line_driver_model (
  // clock and symbol restart
  input wire logic core_clk,
  input wire logic restart,
  // driver controls
  input wire logic signed [7:0] sample,
  input wire logic sample_valid,
  // captured symbol
  output logic signed [7:0] cap [16],
  output logic [4:0] n
);
  // a new symbol restarts capture; extra samples past 16 are dropped, not wrapped
  always @(posedge core_clk) begin
    if (restart) begin
      n <= 5'h00;
    end else if (sample_valid && n < 5'h10) begin
      cap[n[3:0]] <= sample;
      n <= n + 5'h01;
    end
  end
endmodule

// >>> verif/tb_tx_pulse_shaper_control.sv
/*
  self-checking bench for the transmit pulse shaper control.
  assumes the apb slave answers within a few cycles and derived outputs lag one cycle.
*/
`timescale 1ns/100ps
module tb_tx_pulse_shaper_control;
  import shaper_pkg::*;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, sample_valid, table_mode, ser_res_sel, err;
  logic [7:0] paddr, e8;
  logic [31:0] pwdata, prdata, q;
  logic signed [7:0] sample;
  logic signed [7:0] cap [16];
  logic [4:0] n;
  logic [1:0] atten_sel;
  sym_t sym_in;
  mfp_t mfp_pins;
  legacy_t legacy_shape;
  line_ctl_t line_ctl;
  int error_cnt, cmp_count;
  // shortest-range t1 samples, two's complement
  logic [7:0] amp [16] = '{8'h2E, 8'h2E, 8'h2E, 8'h2C, 8'h2C, 8'h2C, 8'h2C, 8'h2C,
    8'h10, 8'hEF, 8'hF2, 8'hF2, 8'hFC, 8'hFC, 8'hFC, 8'hFC};
  // port codes, control, pins and expected float/termination levels
  // last three entries reach the termination input on port a and float-select on port b
  logic [11:0] port_v [10] = '{12'h008, 12'h008, 12'h00E, 12'h00E, 12'h000, 12'h8D0, 12'h8D0,
    12'h080, 12'h080, 12'hD00};
  logic [7:0] ctrl_v [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'hC0, 8'hC0, 8'h80, 8'h80, 8'h00};
  logic [2:0] pin_v [10] = '{3'h4, 3'h0, 3'h0, 3'h4, 3'h0, 3'h3, 3'h0, 3'h2, 3'h0, 3'h1};
  logic [2:0] exp_v [10] = '{3'h4, 3'h0, 3'h4, 3'h0, 3'h4, 3'h1, 3'h2, 3'h1, 3'h0, 3'h2};

  tx_pulse_shaper_control dut (
    .core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sym_in(sym_in), .mfp_pins(mfp_pins), .sample(sample), .sample_valid(sample_valid),
    .legacy_shape(legacy_shape), .table_mode(table_mode), .atten_sel(atten_sel),
    .ser_res_sel(ser_res_sel), .line_ctl(line_ctl)
  );
  line_driver_model drv (
    .core_clk(core_clk), .restart(sym_in.start), .sample(sample), .sample_valid(sample_valid),
    .cap(cap), .n(n)
  );

  // 250 MHz
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      error_cnt++;
      $display("unexpected apb wait at %h: expected pready seen none", a);
      end_of_test;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, q);
  endtask

  // derived outputs lag their registers by one cycle
  task settle;
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sym_in = '0;
    mfp_pins = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    // defaults after reset
    rd(OFS_CTRL, 32'h00);
    rd(OFS_LEG0, 32'h7B);
    rd(OFS_LEG1, 32'h03);
    rd(OFS_LEG2, 32'h40);
    chk("legacy_shape", 32'h7B0340, legacy_shape);
    chk("table_mode", 32'h0, table_mode);
    for (int k = 0; k < 16; k++) rd(8'h40 + 8'(4 * k), k < 8 ? 32'h38 : 32'h00);
    rd(8'h18, 32'h0);
    chk("pslverr", 32'h1, err);
    $display("test reset done");
    // build-out over all four settings in t1, then outside t1
    wr(OFS_LEG0, 32'hFA);
    wr(OFS_LEG1, 32'h26);
    wr(OFS_LEG2, 32'h01);
    for (int l = 0; l < 4; l++) begin
      wr(OFS_CTRL, 32'(l * 2 + 8));
      settle;
      chk("atten_sel", 32'(l), atten_sel);
      chk("legacy_shape", l != 0 ? 32'hD72201 : 32'hFA2601, legacy_shape);
    end
    wr(OFS_CTRL, 32'h16);
    settle;
    chk("atten_sel", 32'h0, atten_sel);
    chk("legacy_shape", 32'hFA2601, legacy_shape);
    chk("ser_res_sel", 32'h1, ser_res_sel);
    $display("test buildout done");
    // one symbol each: legacy, table positive, table negative, all under build-out
    for (int k = 0; k < 16; k++) wr(8'h40 + 8'(4 * k), {24'h0, amp[k]});
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTRL, i != 0 ? 32'h0D : 32'h0C);
      settle;
      chk("table_mode", 32'(i != 0), table_mode);
      @(posedge core_clk);
      sym_in <= '{start: 1'b1, mark: 1'b1, neg: i == 2};
      @(posedge core_clk);
      sym_in <= '0;
      repeat (20) @(posedge core_clk);
      chk("sample count", 32'h10, n);
      for (int k = 0; k < 16; k++) begin
        e8 = i == 0 ? 8'h00 : (i == 1 ? amp[k] : 8'h00 - amp[k]);
        chk("sample", {24'h0, e8}, {24'h0, cap[k]});
      end
    end
    $display("test symbols done");
    // float inputs, soft float bit and termination switch
    for (int e = 0; e < 10; e++) begin
      wr(OFS_PORT, {20'h0, port_v[e]});
      wr(OFS_CTRL, {24'h0, ctrl_v[e]});
      @(posedge core_clk);
      mfp_pins <= pin_v[e];
      settle;
      chk("line_ctl", {29'h0, exp_v[e]}, line_ctl);
    end
    $display("test float done");
    end_of_test;
  end
endmodule
